// ### hdl/dgp_pkg.sv
// constants and types for the dual gpio port block
package dgp_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_P1_DIR = 8'h9F;
  localparam logic [7:0] ADDR_P2_DIR = 8'hAF;
  localparam logic [7:0] ADDR_P1_IN  = 8'hBF;
  localparam logic [7:0] ADDR_P1_OUT = 8'hDF;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_P1_DIR  = 8'h00;
  localparam logic [7:0] RST_P2_DIR  = 8'h00;
  localparam logic [7:0] RST_P1_IN   = 8'hFF;
  localparam logic [7:0] RST_P1_OUT  = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ------------------------------------------------------------
  // mode straps and alternate pins
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_SEL0   = 2'h0;
  localparam logic [1:0] MODE_SEL1   = 2'h1;
  localparam logic [1:0] MODE_SEL2   = 2'h2;
  localparam int         P2_INT_BIT  = 6;
  localparam int         P2_WRH_BIT  = 7;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 4;
  localparam int READY_WAIT_NS  = 12;
  localparam int READY_WAIT_CYC = (READY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    DGP_MODE0,
    DGP_MODE1,
    DGP_MODE2,
    DGP_MODE3,
    DGP_SERIAL
  } dgp_mode_type;
  typedef enum logic [1:0] {
    DGP_ST_IDLE,
    DGP_ST_WAIT,
    DGP_ST_HOLD
  } dgp_bus_type;
endpackage

// ### hdl/dgp_rst_sync.sv
// two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
module dgp_rst_sync (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  output logic      rst_sync_b
);
  logic meta_q;
  logic meta_d;
  logic sync_d;

  always_comb begin
    meta_d = 1'b1;
    sync_d = meta_q;
  end

  // assert at once, release two edges later
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q     <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      meta_q     <= meta_d;
      rst_sync_b <= sync_d;
    end
  end
endmodule

// ### hdl/dgp_port.sv
// two 8-bit gpio ports with host strobe and ready pacing
`timescale 1ns/1ps
module dgp_port #(
  parameter int WAIT_CYC = dgp_pkg::READY_WAIT_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] mode_pins,
  input  wire logic       host_rd_b,
  input  wire logic       host_wr_b,
  input  wire logic [7:0] host_addr,
  input  wire logic [7:0] host_data_i,
  output logic      [7:0] host_data_o,
  output logic            host_data_oe,
  input  wire logic       host_ready_i,
  output logic            host_ready_o,
  output logic            host_ready_oe,
  input  wire logic       host_int_b,
  input  wire logic [7:0] port1_pins_i,
  output logic      [7:0] port1_pins_o,
  output logic      [7:0] port1_pins_oe,
  output logic            port1_pullup,
  input  wire logic [7:0] port2_pins_i,
  output logic      [7:0] port2_pins_o,
  output logic      [7:0] port2_pins_oe,
  input  wire logic [7:0] port2_drive,
  output logic      [7:0] port2_level,
  output logic            port2_wrh_b
);
  // ------------------------------------------------------------
  // checks and reset
  // ------------------------------------------------------------
  if (WAIT_CYC < 1 || WAIT_CYC > 255) begin : g_bad_wait
    $error("WAIT_CYC must lie in 1..255");
  end

  localparam int RDY_MAX = 255;

  logic rst_n_s;

  dgp_rst_sync u_rst (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .rst_sync_b (rst_n_s)
  );

  function automatic logic gpio_mode(input dgp_pkg::dgp_mode_type m);
    return m == dgp_pkg::DGP_MODE0 || m == dgp_pkg::DGP_MODE2 || m == dgp_pkg::DGP_SERIAL;
  endfunction

  function automatic logic host_mode(input dgp_pkg::dgp_mode_type m);
    return m == dgp_pkg::DGP_MODE0 || m == dgp_pkg::DGP_MODE1;
  endfunction

  // ------------------------------------------------------------
  // mode strap, caught on the first edge after release
  // ------------------------------------------------------------
  dgp_pkg::dgp_mode_type mode_q;
  dgp_pkg::dgp_mode_type mode_d;
  logic                  strap_q;
  logic                  strap_d;

  always_comb begin
    mode_d  = mode_q;
    strap_d = 1'b1;
    if (!strap_q) begin
      case (mode_pins)
        dgp_pkg::MODE_SEL0: begin
          mode_d = (!host_rd_b && !host_wr_b) ? dgp_pkg::DGP_SERIAL : dgp_pkg::DGP_MODE0;
        end
        dgp_pkg::MODE_SEL1: mode_d = dgp_pkg::DGP_MODE1;
        dgp_pkg::MODE_SEL2: mode_d = dgp_pkg::DGP_MODE2;
        default:            mode_d = dgp_pkg::DGP_MODE3;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      mode_q  <= dgp_pkg::DGP_MODE0;
      strap_q <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      strap_q <= strap_d;
    end
  end

  // ------------------------------------------------------------
  // bus cycle pacing
  // ------------------------------------------------------------
  dgp_pkg::dgp_bus_type st_q;
  dgp_pkg::dgp_bus_type st_d;
  logic [7:0]           cnt_q;
  logic [7:0]           cnt_d;
  logic                 rd_act_q;
  logic                 rd_act_d;
  logic                 start;
  logic                 wr_p1_dir;
  logic                 wr_p2_dir;
  logic                 wr_p1_out;
  logic [7:0]           data_d;
  logic                 data_oe_d;
  logic                 rdy_oe_d;
  logic [7:0]           p1_dir_q;
  logic [7:0]           p2_dir_q;
  logic [7:0]           p1_in_q;
  logic [7:0]           p1_out_q;

  // strobes are ignored until the strap is known
  assign start     = strap_q && host_mode(mode_q) && st_q == dgp_pkg::DGP_ST_IDLE
                     && (!host_rd_b || !host_wr_b);
  assign wr_p1_dir = start && !host_wr_b && host_addr == dgp_pkg::ADDR_P1_DIR;
  assign wr_p2_dir = start && !host_wr_b && host_addr == dgp_pkg::ADDR_P2_DIR;
  assign wr_p1_out = start && !host_wr_b && host_addr == dgp_pkg::ADDR_P1_OUT;

  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    rd_act_d = rd_act_q;
    case (st_q)
      dgp_pkg::DGP_ST_IDLE: begin
        if (start) begin
          st_d     = dgp_pkg::DGP_ST_WAIT;
          cnt_d    = 8'(WAIT_CYC - 1);
          rd_act_d = !host_rd_b;
        end
      end
      dgp_pkg::DGP_ST_WAIT: begin
        if (cnt_q == 8'h00) begin
          st_d = dgp_pkg::DGP_ST_HOLD;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      dgp_pkg::DGP_ST_HOLD: begin
        // the host has seen ready and ends its cycle
        if (host_rd_b && host_wr_b) begin
          st_d     = dgp_pkg::DGP_ST_IDLE;
          rd_act_d = 1'b0;
        end
      end
      default: begin
        st_d     = dgp_pkg::DGP_ST_IDLE;
        rd_act_d = 1'b0;
      end
    endcase
    rdy_oe_d  = st_d == dgp_pkg::DGP_ST_WAIT;
    data_oe_d = rd_act_d && !host_rd_b;
    case (host_addr)
      dgp_pkg::ADDR_P1_DIR: data_d = p1_dir_q;
      dgp_pkg::ADDR_P2_DIR: data_d = p2_dir_q;
      dgp_pkg::ADDR_P1_IN:  data_d = p1_in_q;
      dgp_pkg::ADDR_P1_OUT: data_d = p1_out_q;
      default:              data_d = dgp_pkg::RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_q          <= dgp_pkg::DGP_ST_IDLE;
      cnt_q         <= 8'h00;
      rd_act_q      <= 1'b0;
      host_data_o   <= dgp_pkg::RD_UNMAPPED;
      host_data_oe  <= 1'b0;
      host_ready_o  <= 1'b0;
      host_ready_oe <= 1'b0;
    end else begin
      st_q          <= st_d;
      cnt_q         <= cnt_d;
      rd_act_q      <= rd_act_d;
      host_data_o   <= data_d;
      host_data_oe  <= data_oe_d;
      host_ready_o  <= 1'b0;  // open drain: only ever pulls low
      host_ready_oe <= rdy_oe_d;
    end
  end

  // ------------------------------------------------------------
  // registers and pins
  // ------------------------------------------------------------
  logic [7:0] p1_dir_d;
  logic [7:0] p2_dir_d;
  logic [7:0] p1_out_d;
  logic       pull_d;
  logic [7:0] p1_oe_d;
  logic [7:0] p2_oe_d;
  logic [7:0] p2_o_d;

  always_comb begin
    p1_dir_d = wr_p1_dir ? host_data_i : p1_dir_q;
    p2_dir_d = wr_p2_dir ? host_data_i : p2_dir_q;
    p1_out_d = wr_p1_out ? host_data_i : p1_out_q;
    pull_d   = port1_pullup && !wr_p1_dir;
    // pins lent to the host bus must not be driven
    p1_oe_d  = gpio_mode(mode_q) ? p1_dir_q : 8'h00;
    p2_oe_d  = p2_dir_q;
    p2_o_d   = port2_drive;
    if (mode_q == dgp_pkg::DGP_MODE1) begin
      p2_oe_d[dgp_pkg::P2_WRH_BIT] = 1'b0;
      p2_oe_d[dgp_pkg::P2_INT_BIT] = 1'b1;
      p2_o_d[dgp_pkg::P2_INT_BIT]  = host_int_b;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      p1_dir_q      <= dgp_pkg::RST_P1_DIR;
      p2_dir_q      <= dgp_pkg::RST_P2_DIR;
      p1_in_q       <= dgp_pkg::RST_P1_IN;
      p1_out_q      <= dgp_pkg::RST_P1_OUT;
      port1_pullup  <= 1'b1;
      port1_pins_o  <= dgp_pkg::RST_P1_OUT;
      port1_pins_oe <= 8'h00;
      port2_pins_o  <= 8'h00;
      port2_pins_oe <= 8'h00;
      port2_level   <= 8'h00;
      port2_wrh_b   <= 1'b1;
    end else begin
      p1_dir_q      <= p1_dir_d;
      p2_dir_q      <= p2_dir_d;
      p1_in_q       <= port1_pins_i;
      p1_out_q      <= p1_out_d;
      port1_pullup  <= pull_d;
      port1_pins_o  <= p1_out_q;
      port1_pins_oe <= p1_oe_d;
      port2_pins_o  <= p2_o_d;
      port2_pins_oe <= p2_oe_d;
      port2_level   <= port2_pins_i;
      port2_wrh_b   <= mode_q == dgp_pkg::DGP_MODE1 ? port2_pins_i[dgp_pkg::P2_WRH_BIT] : 1'b1;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_s);

  a_p1_dir_write: assert property (wr_p1_dir |=> p1_dir_q == $past(host_data_i))
    else $error("port1 direction write lost");
  a_p1_oe_follow: assert property (gpio_mode(mode_q) && $stable(mode_q) |=>
    port1_pins_oe == $past(p1_dir_q))
    else $error("port1 enables do not follow direction");
  a_pull_drop: assert property (wr_p1_dir |=> !port1_pullup ##1 !port1_pullup)
    else $error("pull-up kept after direction write");
  a_pull_keep: assert property (port1_pullup && !wr_p1_dir |=> port1_pullup)
    else $error("pull-up lost without direction write");
  a_reset_vals: assert property ($rose(rst_n_s) |-> p1_dir_q == dgp_pkg::RST_P1_DIR
    && p1_in_q == dgp_pkg::RST_P1_IN && p2_dir_q == dgp_pkg::RST_P2_DIR)
    else $error("bad register reset value");
  a_p1_in_read: assert property (start && !host_rd_b && $past(rst_n_s)
    && host_addr == dgp_pkg::ADDR_P1_IN |=> host_data_o == $past(port1_pins_i, 2))
    else $error("port1 input read wrong");
  a_p1_out_drive: assert property (wr_p1_out |->
    ##2 port1_pins_o == $past(host_data_i, 2))
    else $error("port1 output level wrong");
  a_p2_dir_write: assert property (wr_p2_dir |=> p2_dir_q == $past(host_data_i))
    else $error("port2 direction write lost");
  a_p2_alt_pins: assert property (mode_q == dgp_pkg::DGP_MODE1 && $stable(mode_q) |=>
    !port2_pins_oe[dgp_pkg::P2_WRH_BIT] && port2_pins_oe[dgp_pkg::P2_INT_BIT])
    else $error("port2 alternate pins wrong");
  a_read_drive: assert property (start && !host_rd_b |=> host_data_oe [*2])
    else $error("read data not driven");
  a_ready_pace: assert property (start |=>
    host_ready_oe ##[0:RDY_MAX] !host_ready_oe)
    else $error("ready not paced");
  a_p1_host_mode: assert property (!gpio_mode(mode_q) && $stable(mode_q) |=>
    port1_pins_oe == 8'h00)
    else $error("port1 driven while lent to host");

  c_read_cycle:  cover property (start && !host_rd_b ##1 host_ready_oe ##[1:8] !host_ready_oe);
  c_write_p1dir: cover property (wr_p1_dir ##2 port1_pins_oe != 8'h00);
  c_mode1_alt:   cover property (mode_q == dgp_pkg::DGP_MODE1 && start);
endmodule

// ### tb/dgp_board_model.sv
// board-side model: pin wires, weak pull-ups and the open-drain ready wire
`timescale 1ns/1ps
module dgp_board_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] p1_o,
  input  wire logic [7:0] p1_oe,
  input  wire logic       p1_pullup,
  input  wire logic [7:0] p1_drv,
  input  wire logic [7:0] p1_en,
  output logic      [7:0] p1_i,
  input  wire logic [7:0] p2_o,
  input  wire logic [7:0] p2_oe,
  output logic      [7:0] p2_i,
  input  wire logic       ready_o,
  input  wire logic       ready_oe,
  output logic            ready_i
);
  // ------------------------------------------------------------
  // wire resolution
  // ------------------------------------------------------------
  // undriven pins without pull-up toggle so a stale value never reads as valid
  logic [7:0] flt_q = 8'h55;
  always @(posedge sys_clk) begin
    flt_q <= ~flt_q;
  end
  function automatic logic [7:0] level(input logic [7:0] o, input logic [7:0] oe,
                                       input logic [7:0] drv, input logic [7:0] en,
                                       input logic pu, input logic [7:0] flt);
    for (int i = 0; i < 8; i++) begin
      level[i] = oe[i] ? o[i] : (en[i] ? drv[i] : (pu ? 1'b1 : flt[i]));
    end
  endfunction
  assign p1_i = level(p1_o, p1_oe, p1_drv, p1_en, p1_pullup, flt_q);
  // far side keeps every port-2 pin driven so pin 7 has a known level
  assign p2_i = level(p2_o, p2_oe, 8'h5A, 8'hFF, 1'b0, flt_q);
  // external pull-up: ready reads high unless the device pulls it down
  assign ready_i = ready_oe ? ready_o : 1'b1;
endmodule

// ### tb/dual_gpio_port_host_strobes_bench.sv
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
module dual_gpio_port_host_strobes_bench;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam int WAIT = 2;
  logic       sys_clk       = 1'b0;
  logic       rst_b         = 1'b0;
  logic [1:0] mode_pins     = 2'h0;
  logic       host_rd_b     = 1'b1;
  logic       host_wr_b     = 1'b1;
  logic [7:0] host_addr     = 8'h00;
  logic [7:0] host_data_i   = 8'h00;
  logic       host_int_b    = 1'b1;
  logic [7:0] port2_drive   = 8'hA5;
  logic [7:0] p1_drv        = 8'h00;
  logic [7:0] p1_en         = 8'h00;
  logic [7:0] host_data_o, port1_pins_i, port1_pins_o, port1_pins_oe;
  logic [7:0] port2_pins_i, port2_pins_o, port2_pins_oe, port2_level, rdata;
  logic       host_data_oe, host_ready_i, host_ready_o, host_ready_oe;
  logic       port1_pullup, port2_wrh_b;
  int         errors        = 0;
  int         samples_checked = 0;
  always #2 sys_clk = ~sys_clk;
  dgp_port #(.WAIT_CYC(WAIT)) uut (
    .sys_clk(sys_clk), .rst_b(rst_b), .mode_pins(mode_pins), .host_rd_b(host_rd_b),
    .host_wr_b(host_wr_b), .host_addr(host_addr), .host_data_i(host_data_i),
    .host_data_o(host_data_o), .host_data_oe(host_data_oe), .host_ready_i(host_ready_i),
    .host_ready_o(host_ready_o), .host_ready_oe(host_ready_oe), .host_int_b(host_int_b),
    .port1_pins_i(port1_pins_i), .port1_pins_o(port1_pins_o),
    .port1_pins_oe(port1_pins_oe), .port1_pullup(port1_pullup),
    .port2_pins_i(port2_pins_i), .port2_pins_o(port2_pins_o),
    .port2_pins_oe(port2_pins_oe), .port2_drive(port2_drive),
    .port2_level(port2_level), .port2_wrh_b(port2_wrh_b));
  dgp_board_model board (
    .sys_clk(sys_clk), .p1_o(port1_pins_o), .p1_oe(port1_pins_oe),
    .p1_pullup(port1_pullup), .p1_drv(p1_drv), .p1_en(p1_en), .p1_i(port1_pins_i),
    .p2_o(port2_pins_o), .p2_oe(port2_pins_oe), .p2_i(port2_pins_i),
    .ready_o(host_ready_o), .ready_oe(host_ready_oe), .ready_i(host_ready_i));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ready is looked at on falling edges, where it equals what the next rising edge samples
  task automatic access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata);
    int n;
    int lo;
    n = 0;
    lo = 0;
    @(posedge sys_clk);
    #1;
    host_addr = addr;
    host_data_i = wdata;
    host_rd_b = ~rd;
    host_wr_b = rd;
    while (host_ready_i !== 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    while (host_ready_i === 1'b0 && n < 20) begin
      @(negedge sys_clk);
      n++;
      lo++;
    end
    if (n >= 20) begin
      errors++;
      results();
    end
    check(8'(lo), 8'(WAIT));
    rdata = host_data_o;
    check({7'h00, host_data_oe}, 8'(rd));
    @(posedge sys_clk);
    #1;
    host_rd_b = 1'b1;
    host_wr_b = 1'b1;
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    access(1'b1, addr, 8'h00);
    check(rdata, exp);
  endtask
  // every change lands 1 ns after a rising edge; outputs are read there too, except inside access, which reads them on falling edges
  task automatic do_reset(input logic [1:0] mode);
    @(posedge sys_clk);
    #1;
    rst_b = 1'b0;
    mode_pins = mode;
    repeat (4) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    results();
  end
  initial begin
    do_reset(2'h0);
    check({7'h00, port1_pullup}, 8'h01);
    check(port1_pins_oe, 8'h00);
    rd_chk(dgp_pkg::ADDR_P1_DIR, 8'h00);
    rd_chk(dgp_pkg::ADDR_P2_DIR, 8'h00);
    rd_chk(dgp_pkg::ADDR_P1_IN, 8'hFF);
    access(1'b0, dgp_pkg::ADDR_P1_OUT, 8'hA5);
    access(1'b0, dgp_pkg::ADDR_P1_DIR, 8'h0F);
    check({7'h00, port1_pullup}, 8'h00);
    check(port1_pins_oe, 8'h0F);
    check(port1_pins_o, 8'hA5);
    rd_chk(dgp_pkg::ADDR_P1_DIR, 8'h0F);
    p1_drv = 8'hC0;
    p1_en = 8'hF0;
    rd_chk(dgp_pkg::ADDR_P1_IN, 8'hC5);
    access(1'b0, dgp_pkg::ADDR_P1_OUT, 8'h0A);
    check(port1_pins_o, 8'h0A);
    access(1'b0, dgp_pkg::ADDR_P1_IN, 8'h00);
    rd_chk(dgp_pkg::ADDR_P1_IN, 8'hCA);
    rd_chk(8'h00, dgp_pkg::RD_UNMAPPED);
    access(1'b0, dgp_pkg::ADDR_P2_DIR, 8'h81);
    check(port2_pins_oe, 8'h81);
    check(port2_pins_o & 8'h81, 8'h81);
    check(port2_level, (8'hA5 & 8'h81) | (8'h5A & 8'h7E));
    rd_chk(dgp_pkg::ADDR_P2_DIR, 8'h81);
    // second reset in mode 1: port 1 serves the bus, port-2 pins 6 and 7 change role
    host_int_b = 1'b0;
    do_reset(2'h1);
    access(1'b0, dgp_pkg::ADDR_P1_DIR, 8'hFF);
    check(port1_pins_oe, 8'h00);
    check(port2_pins_oe & 8'hC0, 8'h40);
    check({7'h00, port2_pins_o[6]}, 8'h00);
    check({7'h00, port2_wrh_b}, 8'h00);
    // serial strap (both strobes low at release), then modes 2 and 3: strobes refused
    host_addr = dgp_pkg::ADDR_P1_DIR;
    host_data_i = 8'hFF;
    host_rd_b = 1'b0;
    host_wr_b = 1'b0;
    for (int m = 0; m < 3; m++) begin
      do_reset(m == 0 ? 2'h0 : 2'(m + 1));
      check({7'h00, host_ready_i}, 8'h01);
      check({7'h00, port1_pullup}, 8'h01);
      check({7'h00, host_data_oe}, 8'h00);
    end
    results();
  end
endmodule
